/* common/sfp_consts.svh */
// Timing counts, pin lane positions and reset values of the serial flash port
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Pin lanes on the four data lines
// ----------------------------------------------------------------------------
`define SFP_LANE_SI      0
`define SFP_LANE_SO      1
`define SFP_LANE_WP      2
`define SFP_LANE_HOLD    3
`define SFP_PULL_MASK    4'hC

// ----------------------------------------------------------------------------
// Timing: system clock and serial clock half period made by the host end
// ----------------------------------------------------------------------------
`define SFP_CLK_NS       40
`define SFP_SCK_HALF_NS  80
`define SFP_SCK_HALF_CYC \
  ((`SFP_SCK_HALF_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SFP_CS_SEEN_RST  1'b0
`define SFP_CS_N_RST     1'b1
`define SFP_HOLD_RST     1'b1
`define SFP_SCK_RST      1'b0

`endif

/* common/sfp_pkg.sv */
// Types and lane helpers shared by both ends of the serial flash port
package sfp_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SFP_W_SINGLE = 2'h0,
    SFP_W_DUAL   = 2'h1,
    SFP_W_QUAD   = 2'h2
  } sfp_width_t;

  typedef enum logic [1:0] {
    SFP_D_IDLE   = 2'h0,
    SFP_D_ACTIVE = 2'h1,
    SFP_D_PAUSED = 2'h2
  } sfp_dev_state_t;

  typedef enum logic [2:0] {
    SFP_H_IDLE  = 3'h0,
    SFP_H_SEL   = 3'h1,
    SFP_H_LOW   = 3'h2,
    SFP_H_HIGH  = 3'h3,
    SFP_H_PLOW  = 3'h4,
    SFP_H_PAUSE = 3'h5
  } sfp_host_state_t;

  // --------------------------------------------------------------------------
  // Lane helpers; so selects lane 1 (device output) for single width
  // --------------------------------------------------------------------------
  function automatic logic [3:0] sfp_lanes(input logic [7:0] v,
                                           input sfp_width_t w,
                                           input logic so);
    case (w)
      SFP_W_DUAL: sfp_lanes = {2'h0, v[7:6]};
      SFP_W_QUAD: sfp_lanes = v[7:4];
      default:    sfp_lanes = so ? {2'h0, v[7], 1'h0} : {3'h0, v[7]};
    endcase
  endfunction : sfp_lanes

  function automatic logic [7:0] sfp_shin(input logic [7:0] v,
                                          input logic [3:0] io,
                                          input sfp_width_t w,
                                          input logic so);
    case (w)
      SFP_W_DUAL: sfp_shin = {v[5:0], io[1:0]};
      SFP_W_QUAD: sfp_shin = {v[3:0], io};
      default:    sfp_shin = {v[6:0], so ? io[1] : io[0]};
    endcase
  endfunction : sfp_shin

  function automatic logic [2:0] sfp_step(input sfp_width_t w);
    case (w)
      SFP_W_DUAL: sfp_step = 3'h2;
      SFP_W_QUAD: sfp_step = 3'h4;
      default:    sfp_step = 3'h1;
    endcase
  endfunction : sfp_step

endpackage : sfp_pkg

/* common/sfp_if.sv */
// Pin-level carrier joining the flash end and the host end
`timescale 1ns/1ns
`include "sfp_consts.svh"
interface sfp_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] dev_o;
  logic [3:0] dev_oe;
  logic [3:0] host_o;
  logic [3:0] host_oe;
  logic [3:0] io;

  // Wire level: host wins a clash, undriven WP and pause lanes float high
  assign io = (host_oe & host_o)
            | (~host_oe & dev_oe & dev_o)
            | (~host_oe & ~dev_oe & `SFP_PULL_MASK);

  modport dev  (input cs_n, input sck, input io,
                output dev_o, output dev_oe);
  modport host (output cs_n, output sck, output host_o, output host_oe,
                input io);
endinterface : sfp_if

/* rtl/sfp_dev_end.sv */
// Flash end of the serial port: pin roles, sampling, launching and pause
//
// Behaviour
// - Sample input bits on serial clock rise
// - Ignore input while deselected
// - Launch read bits on serial clock fall
// - Output lines released while deselected
// - WP role needs quad off, protect bits 0,1
// - WP low locks status register writes
// - Quad enabled: WP lane is quad_line_2
// - WP and pause lanes pulled high
// - Quad off: fourth lane is pause input
// - Quad enabled: pause lane is quad_line_3
// - Pause keeps bit position, resumes exactly
// - Pause honoured only while selected
// - Pause entered on fall, clock low
// - Pause left on rise, clock low
// - Select fall starts, rise ends; fall needed
// - Serial clock modes 0 and 3
// - Quad width only when quad enabled
`timescale 1ns/1ns
`include "sfp_consts.svh"
module sfp_dev_end (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst_b,
  input  wire logic                i_ce,
  sfp_if.dev                       bus,
  input  wire logic                i_quad_en,
  input  wire logic                i_prot_bit1,
  input  wire logic                i_prot_bit0,
  input  wire sfp_pkg::sfp_width_t i_width,
  input  wire logic                i_dir_out,
  input  wire logic [7:0]          i_tx_byte,
  output logic                     o_tx_take,
  output logic [7:0]               o_rx_byte,
  output logic                     o_rx_valid,
  output logic                     o_sel_start,
  output logic                     o_sel_end,
  output logic                     o_paused,
  output logic                     o_sr_wr_lock
);
  import sfp_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  sfp_dev_state_t st_q, st_d;
  logic           cs_seen_q, cs_seen_d;
  logic           sck_p_q, sck_p_d;
  logic           hold_p_q, hold_p_d;
  logic [2:0]     cnt_q, cnt_d;
  logic [7:0]     rx_q, rx_d;
  logic [7:0]     tx_q, tx_d;
  logic [3:0]     out_q, out_d;
  logic [3:0]     mask_q, mask_d;
  logic [7:0]     rxb_q, rxb_d;
  logic           rxv_q, rxv_d;
  logic           take_q, take_d;
  logic           start_q, start_d;
  logic           end_q, end_d;
  logic           lock_q, lock_d;

  // --------------------------------------------------------------------------
  // Pin decode
  // --------------------------------------------------------------------------
  sfp_width_t w;
  logic [2:0] step;
  logic       cs_fall;
  logic       sck_rise;
  logic       sck_fall;
  logic       hold_role;
  logic       hold_fall;
  logic       hold_rise;
  logic       wp_role;
  logic [7:0] src;

  // Quad width falls back to single when quad mode is off
  assign w = (i_width == SFP_W_QUAD && !i_quad_en) ? SFP_W_SINGLE
                                                   : i_width;
  assign step = sfp_step(w);

  // Only a fall after a seen high counts, so select low at start-up waits
  assign cs_fall = cs_seen_q & ~bus.cs_n;

  // Clock edges from the previous sample; either idle level works
  assign sck_rise = bus.sck & ~sck_p_q;
  assign sck_fall = ~bus.sck & sck_p_q;

  // Pause lane is an input only with quad mode off
  assign hold_role = ~i_quad_en;
  assign hold_fall = hold_role & hold_p_q & ~bus.io[`SFP_LANE_HOLD]
                   & ~bus.sck;
  assign hold_rise = hold_role & ~hold_p_q & bus.io[`SFP_LANE_HOLD]
                   & ~bus.sck;

  // Write protect role needs quad off and protect bits 0 then 1
  assign wp_role = ~i_quad_en & ~i_prot_bit1 & i_prot_bit0;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    cs_seen_d = bus.cs_n;
    sck_p_d   = bus.sck;
    hold_p_d  = bus.io[`SFP_LANE_HOLD];
    cnt_d     = cnt_q;
    rx_d      = rx_q;
    tx_d      = tx_q;
    out_d     = out_q;
    mask_d    = mask_q;
    rxb_d     = rxb_q;
    rxv_d     = 1'b0;
    take_d    = 1'b0;
    start_d   = 1'b0;
    end_d     = 1'b0;
    src       = (cnt_q == 3'h0) ? i_tx_byte : tx_q;
    lock_d    = wp_role & ~bus.io[`SFP_LANE_WP];
    case (st_q)
      SFP_D_IDLE: begin
        // Anything on the input lane while idle is dropped
        if (cs_fall) begin
          st_d    = SFP_D_ACTIVE;
          cnt_d   = 3'h0;
          mask_d  = 4'h0;
          start_d = 1'b1;
        end
      end
      SFP_D_ACTIVE: begin
        if (bus.cs_n) begin
          st_d   = SFP_D_IDLE;
          mask_d = 4'h0;
          end_d  = 1'b1;
        end else if (hold_fall) begin
          st_d = SFP_D_PAUSED;
        end else if (!i_dir_out && sck_rise) begin
          rx_d  = sfp_shin(rx_q, bus.io, w, 1'b0);
          cnt_d = cnt_q + step;
          if (cnt_d == 3'h0) begin
            rxb_d = sfp_shin(rx_q, bus.io, w, 1'b0);
            rxv_d = 1'b1;
          end
        end else if (i_dir_out && sck_fall) begin
          take_d = (cnt_q == 3'h0);
          out_d  = sfp_lanes(src, w, 1'b1);
          mask_d = sfp_lanes(8'hFF, w, 1'b1);
          tx_d   = src << step;
          cnt_d  = cnt_q + step;
        end
      end
      SFP_D_PAUSED: begin
        // Counters and shifters are left alone, so the byte resumes
        if (bus.cs_n) begin
          st_d   = SFP_D_IDLE;
          mask_d = 4'h0;
          end_d  = 1'b1;
        end else if (hold_rise || !hold_role) begin
          st_d = SFP_D_ACTIVE;
        end
      end
      default: begin
        st_d = SFP_D_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers; the clock enable freezes everything
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q      <= SFP_D_IDLE;
      cs_seen_q <= `SFP_CS_SEEN_RST;
      sck_p_q   <= `SFP_SCK_RST;
      hold_p_q  <= `SFP_HOLD_RST;
      cnt_q     <= 3'h0;
      rx_q      <= 8'h00;
      tx_q      <= 8'h00;
      out_q     <= 4'h0;
      mask_q    <= 4'h0;
      rxb_q     <= 8'h00;
      rxv_q     <= 1'b0;
      take_q    <= 1'b0;
      start_q   <= 1'b0;
      end_q     <= 1'b0;
      lock_q    <= 1'b0;
    end else if (i_ce) begin
      st_q      <= st_d;
      cs_seen_q <= cs_seen_d;
      sck_p_q   <= sck_p_d;
      hold_p_q  <= hold_p_d;
      cnt_q     <= cnt_d;
      rx_q      <= rx_d;
      tx_q      <= tx_d;
      out_q     <= out_d;
      mask_q    <= mask_d;
      rxb_q     <= rxb_d;
      rxv_q     <= rxv_d;
      take_q    <= take_d;
      start_q   <= start_d;
      end_q     <= end_d;
      lock_q    <= lock_d;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drive: enables drop at once on deselect, one system clock later on pause
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_pin
    assign bus.dev_o[g]  = out_q[g];
    assign bus.dev_oe[g] = mask_q[g] & (st_q == SFP_D_ACTIVE)
                         & ~bus.cs_n;
  end

  // User-side outputs
  assign o_tx_take    = take_q;
  assign o_rx_byte    = rxb_q;
  assign o_rx_valid   = rxv_q;
  assign o_sel_start  = start_q;
  assign o_sel_end    = end_q;
  assign o_paused     = (st_q == SFP_D_PAUSED);
  assign o_sr_wr_lock = lock_q;

endmodule : sfp_dev_end

/* rtl/sfp_host_end.sv */
// Host end of the serial port: chip select, clock divider, lanes and pause
`timescale 1ns/1ns
`include "sfp_consts.svh"
module sfp_host_end (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst_b,
  input  wire logic                i_ce,
  sfp_if.host                      bus,
  input  wire logic                i_sel,
  input  wire logic                i_mode3,
  input  wire logic                i_quad_en,
  input  wire sfp_pkg::sfp_width_t i_width,
  input  wire logic                i_dir_in,
  input  wire logic                i_tx_valid,
  input  wire logic [7:0]          i_tx_byte,
  output logic                     o_tx_ready,
  output logic [7:0]               o_rx_byte,
  output logic                     o_rx_valid,
  input  wire logic                i_pause,
  input  wire logic                i_wp_n,
  output logic                     o_paused
);
  import sfp_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  localparam logic [3:0] HALF = 4'(`SFP_SCK_HALF_CYC - 1);

  sfp_host_state_t st_q, st_d;
  logic            cs_n_q, cs_n_d;
  logic            sck_q, sck_d;
  logic [3:0]      tim_q, tim_d;
  logic [2:0]      cnt_q, cnt_d;
  logic [7:0]      sh_q, sh_d;
  sfp_width_t      w_q, w_d;
  logic            rd_q, rd_d;
  logic [3:0]      do_q, do_d;
  logic [3:0]      doe_q, doe_d;
  logic            hold_q, hold_d;
  logic            wp_q, wp_d;
  logic [7:0]      rxb_q, rxb_d;
  logic            rxv_q, rxv_d;
  sfp_width_t      w_eff;
  logic            pause_ok;

  // Quad transfers are never issued with quad mode off
  assign w_eff = (i_width == SFP_W_QUAD && !i_quad_en) ? SFP_W_SINGLE
                                                       : i_width;
  // Pause only while selected and with the pause lane in its pause role
  assign pause_ok = i_pause & ~i_quad_en;
  assign o_tx_ready = (st_q == SFP_H_SEL) & i_sel & ~pause_ok;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    cs_n_d = cs_n_q;
    sck_d  = sck_q;
    tim_d  = tim_q + 4'h1;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    w_d    = w_q;
    rd_d   = rd_q;
    do_d   = do_q;
    doe_d  = doe_q;
    hold_d = hold_q;
    wp_d   = ~i_quad_en & ~i_wp_n;
    rxb_d  = rxb_q;
    rxv_d  = 1'b0;
    case (st_q)
      SFP_H_IDLE: begin
        cs_n_d = 1'b1;
        sck_d  = i_mode3;
        if (i_sel) begin
          st_d   = SFP_H_SEL;
          cs_n_d = 1'b0;
        end
      end
      SFP_H_SEL: begin
        if (!i_sel) begin
          // Back to idle level with select high ends the operation
          st_d   = SFP_H_IDLE;
          cs_n_d = 1'b1;
          sck_d  = i_mode3;
          doe_d  = 4'h0;
        end else if (pause_ok) begin
          st_d  = SFP_H_PLOW;
          sck_d = 1'b0;
          tim_d = 4'h0;
        end else if (i_tx_valid) begin
          // Mode 0 gives no leading fall on the first byte after select,
          // so a read there must follow a byte, as a command byte does
          st_d  = SFP_H_LOW;
          sck_d = 1'b0;
          tim_d = 4'h0;
          cnt_d = 3'h0;
          sh_d  = i_tx_byte;
          w_d   = w_eff;
          rd_d  = i_dir_in;
          do_d  = sfp_lanes(i_tx_byte, w_eff, 1'b0);
          doe_d = i_dir_in ? 4'h0 : sfp_lanes(8'hFF, w_eff, 1'b0);
        end
      end
      SFP_H_LOW: begin
        // Rise at the end of the low half: the flash samples, we sample
        if (tim_q == HALF) begin
          st_d  = SFP_H_HIGH;
          sck_d = 1'b1;
          tim_d = 4'h0;
          cnt_d = cnt_q + sfp_step(w_q);
          sh_d  = rd_q ? sfp_shin(sh_q, bus.io, w_q, 1'b1)
                       : sh_q << sfp_step(w_q);
        end
      end
      SFP_H_HIGH: begin
        if (tim_q == HALF) begin
          tim_d = 4'h0;
          if (cnt_q == 3'h0) begin
            st_d  = SFP_H_SEL;
            doe_d = 4'h0;
            rxb_d = sh_q;
            rxv_d = rd_q;
          end else begin
            st_d  = SFP_H_LOW;
            sck_d = 1'b0;
            do_d  = sfp_lanes(sh_q, w_q, 1'b0);
          end
        end
      end
      SFP_H_PLOW: begin
        // Clock is low a full half before pause drops
        if (tim_q == HALF) begin
          st_d   = SFP_H_PAUSE;
          hold_d = 1'b1;
        end
      end
      SFP_H_PAUSE: begin
        if (!pause_ok) begin
          st_d   = SFP_H_SEL;
          hold_d = 1'b0;
        end
      end
      default: begin
        st_d = SFP_H_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers; the clock enable freezes everything
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q   <= SFP_H_IDLE;
      cs_n_q <= `SFP_CS_N_RST;
      sck_q  <= `SFP_SCK_RST;
      tim_q  <= 4'h0;
      cnt_q  <= 3'h0;
      sh_q   <= 8'h00;
      w_q    <= SFP_W_SINGLE;
      rd_q   <= 1'b0;
      do_q   <= 4'h0;
      doe_q  <= 4'h0;
      hold_q <= 1'b0;
      wp_q   <= 1'b0;
      rxb_q  <= 8'h00;
      rxv_q  <= 1'b0;
    end else if (i_ce) begin
      st_q   <= st_d;
      cs_n_q <= cs_n_d;
      sck_q  <= sck_d;
      tim_q  <= tim_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      w_q    <= w_d;
      rd_q   <= rd_d;
      do_q   <= do_d;
      doe_q  <= doe_d;
      hold_q <= hold_d;
      wp_q   <= wp_d;
      rxb_q  <= rxb_d;
      rxv_q  <= rxv_d;
    end
  end

  // --------------------------------------------------------------------------
  // Pins: protect and pause drive low only, else the pull-up holds them
  // --------------------------------------------------------------------------
  assign bus.cs_n    = cs_n_q;
  assign bus.sck     = sck_q;
  assign bus.host_o  = do_q & {~hold_q, ~wp_q, 2'h3};
  assign bus.host_oe = doe_q | {hold_q, wp_q, 2'h0};
  assign o_rx_byte   = rxb_q;
  assign o_rx_valid  = rxv_q;
  assign o_paused    = (st_q == SFP_H_PAUSE);

endmodule : sfp_host_end

/* tb/sfp_link_properties.sv */
// Pin-level checks on the link between the flash end and the host end
`timescale 1ns/1ns
module sfp_link_properties (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic [3:0] dev_o,
  input  wire logic [3:0] dev_oe,
  input  wire logic [3:0] host_o,
  input  wire logic [3:0] host_oe,
  input  wire logic [3:0] io
);
  // ----------------------------
  // Helpers
  // ----------------------------
  // Host holds the pause lane low outside quad traffic
  logic pause_hold;
  assign pause_hold = !cs_n && host_oe[3] && !host_o[3] && !host_oe[0];

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  AST_DESEL_HIZ: assert property (
    cs_n |-> dev_oe == 4'h0)
    else $error("device drives a lane while deselected");
  // Edge detect costs one sample: the fall lies between the last two samples
  AST_LAUNCH_ON_FALL: assert property (
    $changed(dev_o) && $stable(dev_oe) && dev_oe != 4'h0 && !cs_n
    |-> !$past(sck) && $past(sck, 2))
    else $error("device output changed away from a clock fall");
  AST_SAMPLE_STABLE: assert property (
    $rose(sck) && !cs_n && host_oe[0] |-> $stable(host_o & host_oe))
    else $error("host data moved at the sampling rise");
  AST_PULL_HIGH: assert property (
    (host_oe[3:2] | dev_oe[3:2]) == 2'h0 |-> io[3:2] == 2'h3)
    else $error("undriven upper lanes not pulled high");
  AST_PAUSE_ENTER_LOW: assert property (
    $fell(io[3]) && !cs_n && !host_oe[0] |-> !$past(sck))
    else $error("pause lane fell with the clock high");
  AST_PAUSE_LEAVE_LOW: assert property (
    $rose(io[3]) && !cs_n && $past(host_oe[3]) && !$past(host_oe[0])
    |-> !sck && !$past(sck))
    else $error("pause lane rose with the clock high");
  AST_PAUSED_RELEASE: assert property (
    pause_hold [*3] |-> dev_oe == 4'h0)
    else $error("device drives a lane while paused");
  AST_SEL_START_QUIET: assert property (
    $fell(cs_n) |-> (dev_oe == 4'h0) [*3])
    else $error("device drove lanes right at select fall");
endmodule : sfp_link_properties

/* tb/tb_top.sv */
// Self-checking bench: both ends of the serial flash port face to face
`timescale 1ns/1ns
module tb_top;
  import sfp_pkg::*;
  typedef struct packed {
    logic       qe;
    logic       mode3;
    sfp_width_t wid;
    logic       rd;
    logic [7:0] hbyte;
    logic [7:0] dbyte;
    logic [7:0] exp_b;
  } sfp_row_t;

  // ----------------------------
  // Stimulus tables
  // ----------------------------
  // Quad width with quad off must fall back to single on both ends
  sfp_row_t   rows [8] = '{
    '{1'b0, 1'b0, SFP_W_SINGLE, 1'b0, 8'hA5, 8'h00, 8'hA5},
    '{1'b0, 1'b1, SFP_W_SINGLE, 1'b1, 8'h00, 8'h3C, 8'h3C},
    '{1'b1, 1'b0, SFP_W_DUAL,   1'b0, 8'h96, 8'h00, 8'h96},
    '{1'b1, 1'b1, SFP_W_DUAL,   1'b1, 8'h00, 8'hC3, 8'hC3},
    '{1'b1, 1'b0, SFP_W_QUAD,   1'b0, 8'h5A, 8'h00, 8'h5A},
    '{1'b1, 1'b1, SFP_W_QUAD,   1'b1, 8'h00, 8'h81, 8'h81},
    '{1'b0, 1'b0, SFP_W_QUAD,   1'b0, 8'h7E, 8'h00, 8'h7E},
    '{1'b0, 1'b1, SFP_W_QUAD,   1'b1, 8'h00, 8'hE7, 8'hE7}};
  // Columns: quad, protect bit1, protect bit0, wp_n, lock expected
  logic [4:0] prot [5] = '{5'h05, 5'h06, 5'h14, 5'h0C, 5'h00};

  logic       i_clk_sys = 1'b0;
  logic       i_rst_b   = 1'b0;
  logic       qe = 1'b0, bit1 = 1'b0, bit0 = 1'b0, dir = 1'b0;
  logic       tx_valid = 1'b0, sel = 1'b0, mode3 = 1'b0;
  logic       pause = 1'b0, wp_n = 1'b1;
  sfp_width_t wid = SFP_W_SINGLE;
  logic [7:0] host_tx = 8'h00, dev_tx = 8'h00;
  logic [7:0] dev_rx, host_rx, got;
  logic       dev_rxv, host_rxv, host_ready, sel_start, dev_paused;
  logic       host_paused, sr_lock, sel_end;
  int         err_total = 0;
  int         comparisons = 0;

  sfp_if u_sfp_if ();
  sfp_dev_end u_sfp_dev_end (
    .i_clk_sys (i_clk_sys), .i_rst_b (i_rst_b), .i_ce (1'b1),
    .bus (u_sfp_if.dev), .i_quad_en (qe), .i_prot_bit1 (bit1),
    .i_prot_bit0 (bit0), .i_width (wid), .i_dir_out (dir),
    .i_tx_byte (dev_tx), .o_tx_take (), .o_rx_byte (dev_rx),
    .o_rx_valid (dev_rxv), .o_sel_start (sel_start), .o_sel_end (sel_end),
    .o_paused (dev_paused), .o_sr_wr_lock (sr_lock));
  sfp_host_end u_sfp_host_end (
    .i_clk_sys (i_clk_sys), .i_rst_b (i_rst_b), .i_ce (1'b1),
    .bus (u_sfp_if.host), .i_sel (sel), .i_mode3 (mode3),
    .i_quad_en (qe), .i_width (wid), .i_dir_in (dir),
    .i_tx_valid (tx_valid), .i_tx_byte (host_tx),
    .o_tx_ready (host_ready), .o_rx_byte (host_rx),
    .o_rx_valid (host_rxv), .i_pause (pause), .i_wp_n (wp_n),
    .o_paused (host_paused));
  sfp_link_properties u_sfp_link_properties (
    .i_clk_sys (i_clk_sys), .i_rst_b (i_rst_b), .cs_n (u_sfp_if.cs_n),
    .sck (u_sfp_if.sck), .dev_o (u_sfp_if.dev_o),
    .dev_oe (u_sfp_if.dev_oe), .host_o (u_sfp_if.host_o),
    .host_oe (u_sfp_if.host_oe), .io (u_sfp_if.io));

  // 25 MHz system clock
  always #20 i_clk_sys = ~i_clk_sys;

  // ----------------------------
  // Tasks
  // ----------------------------
  task automatic results();
    $display("Comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Inputs move one step after the rising edge
  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask : tick

  function automatic logic flag(input int k);
    case (k)
      0:       flag = dev_rxv;
      1:       flag = host_rxv;
      2:       flag = host_ready;
      3:       flag = sel_start;
      4:       flag = dev_paused;
      5:       flag = u_sfp_if.cs_n;
      7:       flag = sel_end;
      default: flag = ~dev_paused;
    endcase
  endfunction : flag

  // Bounded wait; running out counts a mismatch and closes the run
  task automatic wait_hi(input int k, input int lim);
    int n;
    n = 0;
    while (flag(k) !== 1'b1) begin
      if (n == lim) begin
        err_total++;
        $display("[FAIL] wait %0d expected 1 seen timeout", k);
        results();
      end
      tick();
      n++;
    end
  endtask : wait_hi

  // One byte through the host: taken at the edge with valid and ready
  task automatic xfer(input logic [7:0] hb, input logic rd,
                      output logic [7:0] g);
    host_tx  = hb;
    dir      = rd;
    tx_valid = 1'b1;
    wait_hi(2, 50);
    tick();
    tx_valid = 1'b0;
    wait_hi(rd ? 1 : 0, 300);
    g = rd ? host_rx : dev_rx;
    wait_hi(2, 50);
  endtask : xfer

  task automatic sel_on();
    sel = 1'b1;
    wait_hi(3, 20);
  endtask : sel_on

  task automatic sel_off();
    sel = 1'b0;
    wait_hi(5, 20);
    wait_hi(7, 20);
    repeat (3) tick();
  endtask : sel_off

  // Main sequence: reset, table rows, then the awkward cases
  initial begin
    repeat (6) @(posedge i_clk_sys);
    #1;
    i_rst_b = 1'b1;
    tick();
    tick();
    chk("cs_n", 8'h01, {7'h0, u_sfp_if.cs_n});
    chk("dev_oe", 8'h00, {4'h0, u_sfp_if.dev_oe});
    chk("pull", 8'h03, {6'h0, u_sfp_if.io[3:2]});
    foreach (rows[i]) begin
      qe     = rows[i].qe;
      mode3  = rows[i].mode3;
      wid    = rows[i].wid;
      dev_tx = rows[i].dbyte;
      tick();
      sel_on();
      xfer(rows[i].hbyte, rows[i].rd, got);
      chk("rx_byte", rows[i].exp_b, got);
      sel_off();
    end
    foreach (prot[i]) begin
      {qe, bit1, bit0, wp_n} = prot[i][4:1];
      repeat (4) tick();
      chk("sr_wr_lock", {7'h0, prot[i][0]}, {7'h0, sr_lock});
      chk("rx_idle", 8'h00, {7'h0, dev_rxv});
    end
    {qe, bit1, bit0, wp_n, mode3} = 5'h02;
    wid    = SFP_W_SINGLE;
    dev_tx = 8'h69;
    tick();
    sel_on();
    // Mode 0 read opens after a command byte, which supplies the first fall
    xfer(8'h0B, 1'b0, got);
    chk("rx_cmd", 8'h0B, got);
    xfer(8'h00, 1'b1, got);
    chk("rx_first", 8'h69, got);
    // Pause between bytes while the next read byte is already launched
    pause = 1'b1;
    wait_hi(4, 40);
    chk("host_paused", 8'h01, {7'h0, host_paused});
    repeat (4) tick();
    chk("dev_oe_paused", 8'h00, {4'h0, u_sfp_if.dev_oe});
    pause = 1'b0;
    wait_hi(6, 40);
    xfer(8'h00, 1'b1, got);
    chk("rx_resumed", 8'h69, got);
    sel_off();
    pause = 1'b1;
    repeat (8) tick();
    chk("paused_desel", 8'h00, {7'h0, dev_paused});
    pause = 1'b0;
    qe    = 1'b1;
    wid   = SFP_W_QUAD;
    tick();
    sel_on();
    pause = 1'b1;
    repeat (8) tick();
    chk("paused_quad", 8'h00, {7'h0, dev_paused});
    xfer(8'hC6, 1'b0, got);
    chk("rx_quad", 8'hC6, got);
    pause = 1'b0;
    // Reset in mid-run while selected, then a fresh select must be seen
    i_rst_b = 1'b0;
    tick();
    chk("cs_n_rst", 8'h01, {7'h0, u_sfp_if.cs_n});
    chk("dev_oe_rst", 8'h00, {4'h0, u_sfp_if.dev_oe});
    i_rst_b = 1'b1;
    wait_hi(3, 20);
    sel_off();
    results();
  end
endmodule : tb_top
